/* File: hdl/qah_axis.sv */
// Quadrature decode, position valid, homing and overtravel for one axis
`timescale 1ns/1ps
module qah_axis (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  // Encoder and switches
  input  wire logic                     phase_a_in,
  input  wire logic                     phase_b_in,
  input  wire logic                     marker_in,
  input  wire logic                     home_switch_in,
  input  wire logic                     positive_travel_limit_in,
  input  wire logic                     negative_travel_limit_in,
  // Configuration
  input  wire logic                     travel_limit_check_enable_in,
  input  wire qah_pkg::qah_home_mode_t  home_mode_in,
  input  wire logic                     motor_dir_neg_in,
  input  wire logic                     continuous_in,
  input  wire logic                     absolute_in,
  input  wire logic                     feedback_type_in,
  input  wire logic                     loop_type_in,
  input  wire logic                     follower_in,
  input  wire logic                     master_is_quadrature_in,
  input  wire logic [1:0]               host_word_counts_in,
  input  wire logic [qah_pkg::POS_W-1:0] high_count_limit_in,
  input  wire logic [qah_pkg::POS_W-1:0] low_count_limit_in,
  input  wire logic [qah_pkg::POS_W-1:0] home_position_in,
  input  wire logic [qah_pkg::POS_W-1:0] home_offset_in,
  input  wire logic [qah_pkg::VEL_W-1:0] search_velocity_in,
  input  wire logic [qah_pkg::VEL_W-1:0] final_velocity_in,
  // Host commands
  input  wire logic                     drive_enable_in,
  input  wire logic                     home_req_in,
  input  wire logic                     abort_req_in,
  input  wire logic                     set_pos_req_in,
  input  wire logic [qah_pkg::POS_W-1:0] set_pos_value_in,
  input  wire logic                     program_start_in,
  input  wire logic [qah_pkg::POS_W-1:0] abs_encoder_pos_in,
  input  wire logic                     abs_restore_in,
  input  wire logic [qah_pkg::POS_W-1:0] aux_position_in,
  // Status
  output logic [qah_pkg::POS_W-1:0]     actual_position_out,
  output logic                          position_valid_out,
  output logic                          quad_error_out,
  output logic                          delta_step_out,
  output logic                          direction_neg_out,
  output logic [7:0]                    alarm_code_out,
  output logic                          program_running_out,
  output logic                          homing_out,
  output logic [qah_pkg::VEL_W-1:0]     cmd_velocity_out,
  output logic                          cmd_dir_neg_out,
  output logic [qah_pkg::POS_W-1:0]     abs_offset_out,
  output logic                          abs_offset_store_out,
  output logic                          config_default_out,
  output logic                          follower_source_ok_out,
  output logic [qah_pkg::POS_W-1:0]     aux_report_out,
  output logic                          aux_report_valid_out
);
  import qah_pkg::*;

  logic a_s, b_s, m_s;
  logic b_prev;
  logic a_chg, b_chg, m_rise;
  logic step, step_neg, both_chg;
  logic fb_prev, loop_prev;
  logic home_prev;
  logic home_start, abort_both, home_done;
  logic [POS_W-1:0] next_pos;
  logic [POS_W-1:0] stepped;
  logic [POS_W-1:0] modulus;
  logic             mod_pow2;
  logic [POS_W-1:0] abs_wrapped;
  logic             limit_fault;
  qah_home_t        hstate;

  // Two flops on each encoder pin first
  qah_sync2 u_sync_a (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (phase_a_in),
    .q_out   (a_s)
  );

  qah_sync2 u_sync_b (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (phase_b_in),
    .q_out   (b_s)
  );

  qah_sync2 u_sync_m (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (marker_in),
    .q_out   (m_s)
  );

  qah_edge u_edge_a (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .lvl_in   (a_s),
    .prev_out (),
    .chg_out  (a_chg),
    .rise_out ()
  );

  qah_edge u_edge_b (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .lvl_in   (b_s),
    .prev_out (b_prev),
    .chg_out  (b_chg),
    .rise_out ()
  );

  qah_edge u_edge_m (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .lvl_in   (m_s),
    .prev_out (),
    .chg_out  (),
    .rise_out (m_rise)
  );

  assign both_chg = a_chg & b_chg;
  assign step     = a_chg ^ b_chg;
  // Forward when new A differs from old B while motor_dir_neg_in is low
  assign step_neg = ~((a_s ^ b_prev) ^ motor_dir_neg_in);

  always_comb
  begin
    if (!step_neg)
      stepped = (continuous_in && actual_position_out == high_count_limit_in)
                ? low_count_limit_in : actual_position_out + POS_ONE;
    else
      stepped = (continuous_in && actual_position_out == low_count_limit_in)
                ? high_count_limit_in : actual_position_out - POS_ONE;
  end

  assign modulus     = high_count_limit_in - low_count_limit_in + POS_ONE;
  assign mod_pow2    = (modulus != POS_ZERO) && ((modulus & (modulus - POS_ONE)) == POS_ZERO);
  assign abs_wrapped = (continuous_in && mod_pow2)
                       ? low_count_limit_in + ((abs_encoder_pos_in + abs_offset_out
                         - low_count_limit_in) & (modulus - POS_ONE))
                       : abs_encoder_pos_in + abs_offset_out;

  // Home is a pulse under drive enable
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      home_prev <= 1'b0;
    else
      home_prev <= home_req_in;
  end
  assign abort_both = home_req_in & abort_req_in;
  assign home_start = home_req_in & ~home_prev & ~abort_req_in & drive_enable_in;

  assign home_done = (hstate == QAH_H_FINAL) && m_rise;

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      hstate <= QAH_H_IDLE;
    else if (abort_req_in || !drive_enable_in)
      hstate <= QAH_H_IDLE;
    else
    begin
      unique case (hstate)
        QAH_H_IDLE:
          if (home_start)
            hstate <= (home_mode_in == QAH_HM_SWITCH) ? QAH_H_SEARCH : QAH_H_FINAL;
        QAH_H_SEARCH:
          if (!home_switch_in)
            hstate <= QAH_H_FINAL;
        QAH_H_FINAL:
          if (m_rise)
            hstate <= QAH_H_IDLE;
        default:
          hstate <= QAH_H_IDLE;
      endcase
    end
  end

  assign homing_out = (hstate != QAH_H_IDLE);

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      cmd_velocity_out <= VEL_ZERO;
      cmd_dir_neg_out  <= 1'b0;
    end
    else
    begin
      unique case (hstate)
        QAH_H_SEARCH:
        begin
          cmd_velocity_out <= search_velocity_in;
          cmd_dir_neg_out  <= ~home_switch_in ^ motor_dir_neg_in;
        end
        QAH_H_FINAL:
        begin
          cmd_velocity_out <= final_velocity_in;
          cmd_dir_neg_out  <= (home_mode_in == QAH_HM_MINUS) ^ motor_dir_neg_in;
        end
        default:
        begin
          cmd_velocity_out <= VEL_ZERO;
          cmd_dir_neg_out  <= motor_dir_neg_in;
        end
      endcase
    end
  end

  // Position register; references win over counting
  always_comb
  begin
    next_pos = actual_position_out;
    if (step)
      next_pos = stepped;
    if (home_done)
      next_pos = home_position_in + home_offset_in;
    if (set_pos_req_in)
      next_pos = set_pos_value_in;
    if (absolute_in && abs_restore_in)
      next_pos = abs_wrapped;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      actual_position_out <= POS_ZERO;
      delta_step_out      <= 1'b0;
      direction_neg_out   <= 1'b0;
    end
    else
    begin
      actual_position_out <= next_pos;
      delta_step_out      <= step;
      if (step)
        direction_neg_out <= step_neg;
    end
  end

  // Error clears valid; reference sets it
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      position_valid_out <= 1'b0;
      quad_error_out     <= 1'b0;
    end
    else
    begin
      quad_error_out <= both_chg;
      // Only error or home+abort clear valid
      if (both_chg || abort_both)
        position_valid_out <= 1'b0;
      else if (home_done || set_pos_req_in || (absolute_in && abs_restore_in))
        position_valid_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      abs_offset_out       <= POS_ZERO;
      abs_offset_store_out <= 1'b0;
    end
    else
    begin
      abs_offset_store_out <= absolute_in && (home_done || set_pos_req_in);
      if (absolute_in && set_pos_req_in)
        abs_offset_out <= set_pos_value_in - abs_encoder_pos_in;
      else if (absolute_in && home_done)
        abs_offset_out <= home_position_in + home_offset_in - abs_encoder_pos_in;
    end
  end

  assign limit_fault = travel_limit_check_enable_in &&
                       (!positive_travel_limit_in || !negative_travel_limit_in);

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      alarm_code_out <= ALARM_NONE;
    else
      alarm_code_out <= limit_fault ? ALARM_OVERTRAVEL : ALARM_NONE;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      program_running_out <= 1'b0;
    else if (!position_valid_out || abort_req_in || limit_fault)
      program_running_out <= 1'b0;
    else if (program_start_in && drive_enable_in)
      program_running_out <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      fb_prev            <= 1'b0;
      loop_prev          <= 1'b0;
      config_default_out <= 1'b0;
    end
    else
    begin
      fb_prev            <= feedback_type_in;
      loop_prev          <= loop_type_in;
      config_default_out <= (fb_prev ^ feedback_type_in) | (loop_prev ^ loop_type_in);
    end
  end

  assign follower_source_ok_out = ~follower_in | master_is_quadrature_in;

  // Report third axis with large words in follower mode
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      aux_report_out       <= POS_ZERO;
      aux_report_valid_out <= 1'b0;
    end
    else
    begin
      aux_report_valid_out <= follower_in && (host_word_counts_in == WORDS_LARGE);
      if (follower_in && host_word_counts_in == WORDS_LARGE)
        aux_report_out <= aux_position_in;
    end
  end
endmodule // qah_axis

/* File: hdl/qah_pkg.sv */
// Constants and types shared by the quadrature axis position and homing logic
// Function
// - Count every single-phase A/B edge, derive delta, direction
// - Block motion programs until position valid
// - Homing or set-position completion sets valid
// - Simultaneous A/B change flags error, clears valid
// - Home plus abort together also clears valid
// - Homing references the once-per-rev marker
// - Search toward switch, then final velocity marker
// - Closed switch means negative side of home
// - Low limit input raises overtravel alarm
// - Limit inputs ignored when checking disabled
// - Feedback/loop type change defaults other settings
// - Power-of-two modulus restores continuous position
// - Absolute mode reference recomputes, stores offset
// - Follower master only from quadrature encoder
// - Larger word counts report third axis position in follower mode
// - Direction setting swaps motion and velocity sign
// - Continuous mode wraps between count limits
package qah_pkg;
  localparam int POS_W = 32;
  localparam int VEL_W = 16;
  localparam logic [7:0] ALARM_NONE       = 8'h00;
  localparam logic [7:0] ALARM_OVERTRAVEL = 8'ha9;
  localparam logic [1:0] WORDS_LARGE      = 2'h1;
  localparam logic [POS_W-1:0] POS_ZERO   = 32'h0000_0000;
  localparam logic [POS_W-1:0] POS_ONE    = 32'h0000_0001;
  localparam logic [VEL_W-1:0] VEL_ZERO   = 16'h0000;
  typedef enum logic [1:0] {
    QAH_H_IDLE   = 2'b00,
    QAH_H_SEARCH = 2'b01,
    QAH_H_FINAL  = 2'b10
  } qah_home_t;
  typedef enum logic [1:0] {
    QAH_HM_SWITCH = 2'b00,
    QAH_HM_PLUS   = 2'b01,
    QAH_HM_MINUS  = 2'b10
  } qah_home_mode_t;
endpackage

/* File: hdl/qah_sync2.sv */
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module qah_sync2 (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Level
  input  wire logic d_in,
  output logic      q_out
);
  logic meta;
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      meta  <= 1'b0;
      q_out <= 1'b0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // qah_sync2

/* File: hdl/qah_edge.sv */
// Edge detector comparing an already synchronised level with its registered previous value
`timescale 1ns/1ps
module qah_edge (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Level and edges
  input  wire logic lvl_in,
  output logic      prev_out,
  output logic      chg_out,
  output logic      rise_out
);
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      prev_out <= 1'b0;
    else
      prev_out <= lvl_in;
  end
  assign chg_out  = lvl_in ^ prev_out;
  assign rise_out = lvl_in & ~prev_out;
endmodule // qah_edge

/* File: dv/qah_enc_model.sv */
// Incremental encoder model on the far side of the axis block
`timescale 1ns/1ps
module qah_enc_model (
  // Commands from the bench
  input  wire logic step_in,
  input  wire logic back_in,
  input  wire logic skew_in,
  // Encoder phases
  output logic      phase_a_out,
  output logic      phase_b_out
);
  logic [1:0] s = 2'h0;
  // One channel per step; skew flips both
  always @(posedge step_in or posedge skew_in)
    if (skew_in)
      s <= s + 2'h2;
    else
      s <= back_in ? s - 2'h1 : s + 2'h1;
  assign phase_a_out = s[0] ^ s[1];
  assign phase_b_out = s[1];
endmodule // qah_enc_model

/* File: dv/qah_assertions.sv */
// Port-level checks for the axis block
`timescale 1ns/1ps
module qah_assertions import qah_pkg::*; (
  // Clock and reset
  input wire logic             clk_in,
  input wire logic             nrst_in,
  // Inputs watched
  input wire logic             phase_a_in,
  input wire logic             phase_b_in,
  input wire logic             home_req_in,
  input wire logic             abort_req_in,
  input wire logic             drive_enable_in,
  input wire logic             set_pos_req_in,
  input wire logic [POS_W-1:0] set_pos_value_in,
  input wire logic             travel_limit_check_enable_in,
  input wire logic             positive_travel_limit_in,
  input wire logic             feedback_type_in,
  // Outputs watched
  input wire logic             program_running_out,
  input wire logic             position_valid_out,
  input wire logic             quad_error_out,
  input wire logic             delta_step_out,
  input wire logic             homing_out,
  input wire logic             config_default_out,
  input wire logic [POS_W-1:0] actual_position_out,
  input wire logic [7:0]       alarm_code_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  prog_gate_a: assert property ($rose(program_running_out) |-> $past(position_valid_out))
    else $error("program started without valid position");
  set_pos_a: assert property (set_pos_req_in && !abort_req_in |=>
    actual_position_out == $past(set_pos_value_in) && (position_valid_out || quad_error_out))
    else $error("set position not taken");
  quad_clear_a: assert property (quad_error_out |-> !position_valid_out)
    else $error("valid kept through quadrature error");
  valid_fall_a: assert property ($fell(position_valid_out) |->
    quad_error_out || ($past(home_req_in) && $past(abort_req_in)))
    else $error("valid cleared without cause");
  edge_sync_a: assert property ($changed(phase_a_in) |=> !delta_step_out)
    else $error("phase edge used before synchronising");
  step_seen_a: assert property ($changed(phase_a_in) && $stable(phase_b_in) |->
    ##[2:5] delta_step_out)
    else $error("phase edge not counted");
  home_start_a: assert property ($rose(home_req_in) && drive_enable_in && !abort_req_in
    && !homing_out |=> homing_out)
    else $error("home request not taken");
  limit_alarm_a: assert property (travel_limit_check_enable_in && !positive_travel_limit_in
    |-> ##[1:3] alarm_code_out == ALARM_OVERTRAVEL)
    else $error("overtravel alarm missing");
  cfg_default_a: assert property ($changed(feedback_type_in) |->
    ##[0:2] config_default_out)
    else $error("settings not defaulted");
  cover property (homing_out ##[1:300] position_valid_out);
  cover property ($rose(quad_error_out));
  cover property ($rose(alarm_code_out == ALARM_OVERTRAVEL));
endmodule // qah_assertions

/* File: dv/qah_axis_bench.sv */
// Self-checking bench for the axis position and homing block
`timescale 1ns/1ps
module qah_axis_bench;
  import qah_pkg::*;
  logic clk_in, nrst_in, phase_a_in, phase_b_in, marker_in, home_switch_in, step, back, skew;
  logic positive_travel_limit_in, negative_travel_limit_in, travel_limit_check_enable_in;
  logic motor_dir_neg_in, continuous_in, absolute_in, feedback_type_in, loop_type_in;
  logic follower_in, master_is_quadrature_in, drive_enable_in, home_req_in, abort_req_in;
  logic set_pos_req_in, program_start_in, abs_restore_in, position_valid_out, quad_error_out;
  logic delta_step_out, direction_neg_out, program_running_out, homing_out, cmd_dir_neg_out;
  logic abs_offset_store_out, config_default_out, follower_source_ok_out, aux_report_valid_out;
  qah_home_mode_t   home_mode_in;
  logic [1:0]       host_word_counts_in;
  logic [7:0]       alarm_code_out;
  logic [POS_W-1:0] high_count_limit_in, low_count_limit_in, home_position_in, home_offset_in;
  logic [POS_W-1:0] set_pos_value_in, abs_encoder_pos_in, aux_position_in;
  logic [POS_W-1:0] actual_position_out, abs_offset_out, aux_report_out;
  logic [VEL_W-1:0] search_velocity_in, final_velocity_in, cmd_velocity_out;
  int               err_count, num_checks, seed, n;

  qah_axis dut (.clk_in, .nrst_in, .phase_a_in, .phase_b_in, .marker_in, .home_switch_in,
    .positive_travel_limit_in, .negative_travel_limit_in, .travel_limit_check_enable_in,
    .home_mode_in, .motor_dir_neg_in, .continuous_in, .absolute_in, .feedback_type_in,
    .loop_type_in, .follower_in, .master_is_quadrature_in, .host_word_counts_in,
    .high_count_limit_in, .low_count_limit_in, .home_position_in, .home_offset_in,
    .search_velocity_in, .final_velocity_in, .drive_enable_in, .home_req_in, .abort_req_in,
    .set_pos_req_in, .set_pos_value_in, .program_start_in, .abs_encoder_pos_in,
    .abs_restore_in, .aux_position_in, .actual_position_out, .position_valid_out,
    .quad_error_out, .delta_step_out, .direction_neg_out, .alarm_code_out, .program_running_out,
    .homing_out, .cmd_velocity_out, .cmd_dir_neg_out, .abs_offset_out, .abs_offset_store_out,
    .config_default_out, .follower_source_ok_out, .aux_report_out, .aux_report_valid_out);
  qah_enc_model enc (.step_in(step), .back_in(back), .skew_in(skew),
    .phase_a_out(phase_a_in), .phase_b_out(phase_b_in));

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask

  task automatic chk(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Steps spaced wide so the synchroniser delay never overlaps
  task automatic move(input logic dir);
    back = dir;
    step = 1'h1;
    cyc(1);
    step = 1'h0;
    cyc(7);
  endtask

  task automatic set_pos(input logic [POS_W-1:0] v);
    set_pos_value_in = v;
    set_pos_req_in = 1'h1;
    cyc(1);
    set_pos_req_in = 1'h0;
  endtask

  // Expected continuous position, from the count limits alone
  function automatic logic [POS_W-1:0] wrap_pos(input logic [POS_W-1:0] p);
    return low_count_limit_in + (p - low_count_limit_in)
           % (high_count_limit_in - low_count_limit_in + POS_ONE);
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    clk_in = 1'h0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial
  begin
    #20000;
    err_count++;
    $display("mismatch at %0t: watchdog", $time);
    results;
  end

  initial
  begin
    {seed, err_count, num_checks, nrst_in} = {32'h23, 32'h0, 32'h0, 1'h0};
    {marker_in, home_switch_in, travel_limit_check_enable_in, motor_dir_neg_in} = '0;
    {continuous_in, absolute_in, feedback_type_in, loop_type_in, home_req_in} = '0;
    {abort_req_in, set_pos_req_in, program_start_in, abs_restore_in, drive_enable_in} = '0;
    {step, back, skew, set_pos_value_in, abs_encoder_pos_in, low_count_limit_in} = '0;
    {positive_travel_limit_in, negative_travel_limit_in, follower_in} = '1;
    {master_is_quadrature_in, host_word_counts_in} = {1'h1, WORDS_LARGE};
    home_mode_in = QAH_HM_SWITCH;
    home_position_in = $random(seed);
    {home_offset_in, aux_position_in} = {$random(seed), $random(seed)};
    {search_velocity_in, final_velocity_in} = $random(seed);
    high_count_limit_in = 32'h0000_00ff;
    cyc(16);
    nrst_in = 1'h1;
    program_start_in = 1'h1;
    cyc(2);
    chk(program_running_out, 1'h0, "program ran unreferenced");
    program_start_in = 1'h0;
    absolute_in = 1'h1;
    set_pos($random(seed));
    chk(actual_position_out, set_pos_value_in, "set position");
    chk(position_valid_out, 1'h1, "valid after set");
    chk(abs_offset_store_out, 1'h1, "offset store");
    {absolute_in, program_start_in, drive_enable_in} = 3'h3;
    cyc(2);
    chk(program_running_out, 1'h1, "program refused");
    $display("reference test done");
    // Start at the high limit so the first step wraps
    {program_start_in, continuous_in} = 2'h1;
    set_pos(high_count_limit_in);
    n = 2 + ($unsigned($random(seed)) % 6);
    repeat (n) move(1'h0);
    chk(actual_position_out, n - 1, "forward count");
    chk(direction_neg_out, 1'h0, "forward direction");
    repeat (n) move(1'h1);
    chk(actual_position_out, high_count_limit_in, "reverse count");
    chk(direction_neg_out, 1'h1, "reverse direction");
    motor_dir_neg_in = 1'h1;
    move(1'h0);
    chk(direction_neg_out, 1'h1, "swapped direction");
    // Travel after the reference, 0x321 counts, exceeds the 256-count range, so the restore wraps
    absolute_in = 1'h1;
    abs_encoder_pos_in = $random(seed);
    set_pos(32'h0000_0040);
    abs_encoder_pos_in = abs_encoder_pos_in + 32'h0000_0321;
    abs_restore_in = 1'h1;
    cyc(1);
    {abs_restore_in, absolute_in} = 2'h0;
    chk(actual_position_out, wrap_pos(32'h0000_0361), "absolute restore");
    chk(abs_offset_store_out, 1'h0, "no store on restore");
    $display("absolute test done");
    {motor_dir_neg_in, skew} = 2'h1;
    cyc(1);
    skew = 1'h0;
    cyc(2);
    chk(quad_error_out, 1'h1, "quadrature error flag");
    cyc(4);
    chk(position_valid_out, 1'h0, "valid after quad error");
    $display("count test done");
    // Home pulsed while drive enable stays held
    {drive_enable_in, home_switch_in, home_req_in} = 3'h7;
    cyc(2);
    home_req_in = 1'h0;
    chk(homing_out, 1'h1, "homing start");
    chk(cmd_velocity_out, search_velocity_in, "search velocity");
    chk(cmd_dir_neg_out, 1'h0, "search side");
    home_switch_in = 1'h0;
    cyc(4);
    chk(cmd_velocity_out, final_velocity_in, "final velocity");
    marker_in = 1'h1;
    cyc(2);
    marker_in = 1'h0;
    cyc(4);
    chk(actual_position_out, home_position_in + home_offset_in, "home load");
    chk(position_valid_out, 1'h1, "valid after home");
    chk(homing_out, 1'h0, "homing end at marker");
    {home_req_in, abort_req_in} = 2'h3;
    cyc(2);
    {home_req_in, abort_req_in} = 2'h0;
    chk(position_valid_out, 1'h0, "valid after home abort");
    home_mode_in = QAH_HM_MINUS;
    cyc(1);
    home_req_in = 1'h1;
    cyc(2);
    home_req_in = 1'h0;
    chk(cmd_velocity_out, final_velocity_in, "direct final velocity");
    chk(cmd_dir_neg_out, 1'h1, "minus approach");
    marker_in = 1'h1;
    cyc(2);
    marker_in = 1'h0;
    cyc(4);
    chk(position_valid_out, 1'h1, "valid after minus home");
    chk(homing_out, 1'h0, "minus homing end");
    $display("homing test done");
    {positive_travel_limit_in, negative_travel_limit_in, master_is_quadrature_in} = '0;
    cyc(3);
    chk(alarm_code_out, ALARM_NONE, "limits ignored");
    chk(follower_source_ok_out, 1'h0, "non-quadrature master");
    {travel_limit_check_enable_in, master_is_quadrature_in, feedback_type_in} = 3'h7;
    cyc(3);
    chk(alarm_code_out, ALARM_OVERTRAVEL, "overtravel alarm");
    chk(follower_source_ok_out, 1'h1, "quadrature master");
    chk(aux_report_valid_out, 1'h1, "third axis flag");
    chk(aux_report_out, aux_position_in, "third axis data");
    loop_type_in = 1'h1;
    cyc(1);
    chk(config_default_out, 1'h1, "defaults on loop type change");
    cyc(2);
    chk(config_default_out, 1'h0, "default pulse ends");
    $display("config test done");
    results;
  end
endmodule // qah_axis_bench

bind qah_axis qah_assertions chk_i (.clk_in, .nrst_in, .phase_a_in, .phase_b_in, .home_req_in,
  .abort_req_in, .drive_enable_in, .set_pos_req_in, .set_pos_value_in,
  .travel_limit_check_enable_in, .positive_travel_limit_in, .feedback_type_in,
  .program_running_out, .position_valid_out, .quad_error_out, .delta_step_out, .homing_out,
  .config_default_out, .actual_position_out, .alarm_code_out);
